// ### logic/ddc_control.sv
// Top of the dual converter control block: registers, update timing, outputs.
module ddc_control (
  // Clock and reset.
  input  wire logic               clk,
  input  wire logic               rst,
  // Special-function register port from the core.
  input  wire logic [7:0]         sfrAddr,
  input  wire logic               sfrWr,
  input  wire logic               sfrRd,
  input  wire ddc_pkg::ddc_byte_t sfrWrData,
  output ddc_pkg::ddc_byte_t      sfrRdData,
  output logic                    sfrRdHit,
  // Buffer bypass configuration from the system configuration register.
  input  wire logic               outputBufferBypass,
  // Converter 0 analog controls.
  output ddc_pkg::ddc_code_t      conv0Code,
  output ddc_pkg::ddc_out_t       conv0OutState,
  output logic                    conv0RangeSelect,
  output logic                    conv0BufferBypass,
  // Converter 1 analog controls.
  output ddc_pkg::ddc_code_t      conv1Code,
  output ddc_pkg::ddc_out_t       conv1OutState,
  output logic                    conv1RangeSelect,
  output logic                    conv1BufferBypass
);
  `include "ddc_regs.svh"

  ////////////////////////////////////////////////////////////////////////////
  // Address decode.

  logic               wrCtrl;
  logic               wrLow0;
  logic               wrHigh0;
  logic               wrLow1;
  logic               wrHigh1;
  ddc_pkg::ddc_byte_t converterControl_reg;
  ddc_pkg::ddc_byte_t conv0CodeLow;
  ddc_pkg::ddc_byte_t conv0CodeHigh;
  ddc_pkg::ddc_byte_t conv1CodeLow;
  ddc_pkg::ddc_byte_t conv1CodeHigh;
  ddc_pkg::ddc_byte_t rdData_next;
  logic               rdHit_next;

  // Write strobes, one per register.
  assign wrCtrl  = sfrWr && (sfrAddr == `DDC_ADDR_CONTROL);
  assign wrLow0  = sfrWr && (sfrAddr == `DDC_ADDR_CONV0_LOW);
  assign wrHigh0 = sfrWr && (sfrAddr == `DDC_ADDR_CONV0_HIGH);
  assign wrLow1  = sfrWr && (sfrAddr == `DDC_ADDR_CONV1_LOW);
  assign wrHigh1 = sfrWr && (sfrAddr == `DDC_ADDR_CONV1_HIGH);

  ////////////////////////////////////////////////////////////////////////////
  // Control register.

  // Power-on value leaves sync set and both converters off.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      converterControl_reg <= `DDC_CTRL_RESET;
    end else if (wrCtrl) begin
      converterControl_reg <= sfrWrData;
    end
  end

  logic mode8;
  logic syncOn;
  // A control write that changes the mode and sets sync at once loads the
  // held codes in the mode it selects, not in the one it replaces.
  assign mode8  = wrCtrl ? sfrWrData[`DDC_BIT_MODE8]
                         : converterControl_reg[`DDC_BIT_MODE8];
  assign syncOn = converterControl_reg[`DDC_BIT_SYNC];

  ////////////////////////////////////////////////////////////////////////////
  // Data registers.

  ddc_code_reg u_code0 (
    .clk     (clk),
    .rst     (rst),
    .wrLow   (wrLow0),
    .wrHigh  (wrHigh0),
    .wrData  (sfrWrData),
    .lowReg  (conv0CodeLow),
    .highReg (conv0CodeHigh)
  );

  ddc_code_reg u_code1 (
    .clk     (clk),
    .rst     (rst),
    .wrLow   (wrLow1),
    .wrHigh  (wrHigh1),
    .wrData  (sfrWrData),
    .lowReg  (conv1CodeLow),
    .highReg (conv1CodeHigh)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Code assembly and update timing.

  ddc_pkg::ddc_code_t staged0;
  ddc_pkg::ddc_code_t staged1;
  ddc_pkg::ddc_code_t stagedNew0;
  ddc_pkg::ddc_code_t stagedNew1;
  logic               syncRise;

  // The code sees the byte being written in the same cycle, so a low-byte
  // write with sync set is visible on the output at the edge that stores it.
  function automatic ddc_pkg::ddc_code_t buildCode(
    input logic               eightBit,
    input ddc_pkg::ddc_byte_t low,
    input ddc_pkg::ddc_byte_t high
  );
    ddc_pkg::ddc_code_t code;
    if (eightBit) begin
      code = {low, 4'h0};
    end else begin
      code = {high[3:0], low};
    end
    return code;
  endfunction

  // Contents including a write in this cycle; each byte from the bus
  // overrides the stored one when its own register is addressed.
  assign stagedNew0 = buildCode(mode8, wrLow0 ? sfrWrData : conv0CodeLow,
                                wrHigh0 ? sfrWrData : conv0CodeHigh);
  assign stagedNew1 = buildCode(mode8, wrLow1 ? sfrWrData : conv1CodeLow,
                                wrHigh1 ? sfrWrData : conv1CodeHigh);
  assign staged0    = stagedNew0;
  assign staged1    = stagedNew1;

  // A write that turns sync from zero to one releases both held codes.
  assign syncRise = wrCtrl && !syncOn && sfrWrData[`DDC_BIT_SYNC];

  // Converter 0 output code.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      conv0Code <= 12'h000;
    end else if (syncRise) begin
      conv0Code <= staged0;
    end else if (syncOn && wrLow0) begin
      conv0Code <= staged0;
    end
  end

  // Converter 1 output code.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      conv1Code <= 12'h000;
    end else if (syncRise) begin
      conv1Code <= staged1;
    end else if (syncOn && wrLow1) begin
      conv1Code <= staged1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Range outputs.

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      conv0RangeSelect <= 1'b0;
      conv1RangeSelect <= 1'b0;
    end else begin
      conv0RangeSelect <= converterControl_reg[`DDC_BIT_RANGE0];
      conv1RangeSelect <= converterControl_reg[`DDC_BIT_RANGE1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output stages.

  ddc_out_stage u_stage0 (
    .clk          (clk),
    .rst          (rst),
    .powerOn      (converterControl_reg[`DDC_BIT_POWER0]),
    .clearN       (converterControl_reg[`DDC_BIT_CLEAR0_N]),
    .rangeSupply  (converterControl_reg[`DDC_BIT_RANGE0]),
    .bypassReq    (outputBufferBypass),
    .outState     (conv0OutState),
    .bufferBypass (conv0BufferBypass)
  );

  ddc_out_stage u_stage1 (
    .clk          (clk),
    .rst          (rst),
    .powerOn      (converterControl_reg[`DDC_BIT_POWER1]),
    .clearN       (converterControl_reg[`DDC_BIT_CLEAR1_N]),
    .rangeSupply  (converterControl_reg[`DDC_BIT_RANGE1]),
    .bypassReq    (outputBufferBypass),
    .outState     (conv1OutState),
    .bufferBypass (conv1BufferBypass)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read-back.

  // All five registers read back as written; other addresses give zero and
  // no hit so the core can route another peripheral's data.
  always_comb begin
    rdData_next = 8'h00;
    rdHit_next  = 1'b1;
    if (sfrAddr == `DDC_ADDR_CONTROL) begin
      rdData_next = converterControl_reg;
    end else if (sfrAddr == `DDC_ADDR_CONV0_LOW) begin
      rdData_next = conv0CodeLow;
    end else if (sfrAddr == `DDC_ADDR_CONV0_HIGH) begin
      rdData_next = conv0CodeHigh;
    end else if (sfrAddr == `DDC_ADDR_CONV1_LOW) begin
      rdData_next = conv1CodeLow;
    end else if (sfrAddr == `DDC_ADDR_CONV1_HIGH) begin
      rdData_next = conv1CodeHigh;
    end else begin
      rdHit_next = 1'b0;
    end
  end

  // Read data registered one cycle after the strobe.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sfrRdData <= 8'h00;
      sfrRdHit  <= 1'b0;
    end else begin
      sfrRdData <= sfrRd ? rdData_next : 8'h00;
      sfrRdHit  <= sfrRd && rdHit_next;
    end
  end
endmodule

// ### logic/ddc_regs.svh
// Register offsets, field positions, reset values for the dual converter control block.
`ifndef DDC_REGS_SVH
`define DDC_REGS_SVH
`define DDC_ADDR_CONV0_LOW  8'hf9
`define DDC_ADDR_CONV0_HIGH 8'hfa
`define DDC_ADDR_CONV1_LOW  8'hfb
`define DDC_ADDR_CONV1_HIGH 8'hfc
`define DDC_ADDR_CONTROL    8'hfd
`define DDC_CTRL_RESET      8'h04
`define DDC_DATA_RESET      8'h00
`define DDC_BIT_MODE8       7
`define DDC_BIT_RANGE1      6
`define DDC_BIT_RANGE0      5
`define DDC_BIT_CLEAR1_N    4
`define DDC_BIT_CLEAR0_N    3
`define DDC_BIT_SYNC        2
`define DDC_BIT_POWER1      1
`define DDC_BIT_POWER0      0
`endif

// ### logic/ddc_pkg.sv
// Types shared by the dual converter control block.
package ddc_pkg;
  typedef logic [7:0] ddc_byte_t;
  typedef logic [11:0] ddc_code_t;
  typedef enum logic [1:0] {
    DDC_OUT_HIZ,
    DDC_OUT_ZERO,
    DDC_OUT_CODE
  } ddc_out_t;
endpackage

// ### logic/ddc_code_reg.sv
// Per-converter data byte pair holding the software-written code bytes.
module ddc_code_reg (
  // Clock and reset.
  input  wire logic              clk,
  input  wire logic              rst,
  // Write port.
  input  wire logic              wrLow,
  input  wire logic              wrHigh,
  input  wire ddc_pkg::ddc_byte_t wrData,
  // Stored bytes, each straight from a register.
  output ddc_pkg::ddc_byte_t     lowReg,
  output ddc_pkg::ddc_byte_t     highReg
);
  `include "ddc_regs.svh"

  // Both bytes clear at power-on.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lowReg  <= `DDC_DATA_RESET;
      highReg <= `DDC_DATA_RESET;
    end else begin
      if (wrLow) begin
        lowReg <= wrData;
      end
      if (wrHigh) begin
        highReg <= wrData;
      end
    end
  end
endmodule

// ### logic/ddc_out_stage.sv
// Output state selection for one converter: high impedance, forced zero or code.
module ddc_out_stage (
  // Clock and reset.
  input  wire logic              clk,
  input  wire logic              rst,
  // Controls.
  input  wire logic              powerOn,
  input  wire logic              clearN,
  input  wire logic              rangeSupply,
  input  wire logic              bypassReq,
  // Registered results.
  output ddc_pkg::ddc_out_t      outState,
  output logic                   bufferBypass
);
  // Disabled after reset so the pin floats until software powers it.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      outState <= ddc_pkg::DDC_OUT_HIZ;
    end else if (!powerOn) begin
      outState <= ddc_pkg::DDC_OUT_HIZ;
    end else if (!clearN) begin
      outState <= ddc_pkg::DDC_OUT_ZERO;
    end else begin
      outState <= ddc_pkg::DDC_OUT_CODE;
    end
  end

  // The unbuffered path is only honoured in the reference range, so the
  // request is dropped while the supply range is selected.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bufferBypass <= 1'b0;
    end else begin
      bufferBypass <= bypassReq && !rangeSupply;
    end
  end
endmodule

// ### verif/ddc_control_monitor.sv
// Checker for the dual converter control block, bound to its top module.
module ddc_control_monitor (
  // Clock and reset.
  input wire logic               clk,
  input wire logic               rst,
  // Register port.
  input wire logic [7:0]         sfrAddr,
  input wire logic               sfrWr,
  input wire logic               sfrRd,
  input wire ddc_pkg::ddc_byte_t sfrWrData,
  input wire logic               sfrRdHit,
  // Converter controls.
  input wire ddc_pkg::ddc_code_t conv0Code,
  input wire ddc_pkg::ddc_code_t conv1Code,
  input wire ddc_pkg::ddc_out_t  conv0OutState,
  input wire ddc_pkg::ddc_out_t  conv1OutState,
  input wire logic               conv0RangeSelect,
  input wire logic               conv1RangeSelect,
  input wire logic               conv0BufferBypass
);
  timeunit 1ns;
  timeprecision 1ps;
  ddc_pkg::ddc_byte_t ctrlReg;
  ddc_pkg::ddc_byte_t low0Reg;
  ddc_pkg::ddc_byte_t high0Reg;
  // Shadow registers, since the checker sees only the port and not the storage.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrlReg <= 8'h04;
      low0Reg <= 8'h00;
      high0Reg <= 8'h00;
    end else if (sfrWr) begin
      if (sfrAddr == 8'hfd) ctrlReg <= sfrWrData;
      if (sfrAddr == 8'hf9) low0Reg <= sfrWrData;
      if (sfrAddr == 8'hfa) high0Reg <= sfrWrData;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // A data write while updates are held.
  sequence heldWrite_s;
    sfrWr && sfrAddr inside {[8'hf9:8'hfc]} && !ctrlReg[2];
  endsequence
  // The control write that releases held data in twelve-bit mode.
  sequence syncRise_s;
    sfrWr && sfrAddr == 8'hfd && !ctrlReg[2] && sfrWrData[2] && !sfrWrData[7];
  endsequence
  read_hit_a: assert property (sfrRd && sfrAddr inside {[8'hf9:8'hfd]} |=> sfrRdHit)
    else $error("mapped read gave no hit");
  wide_update_a: assert property (sfrWr && sfrAddr == 8'hf9 && ctrlReg[2] && !ctrlReg[7]
    |=> conv0Code == {high0Reg[3:0], low0Reg}) else $error("twelve-bit code wrong");
  narrow_update_a: assert property (sfrWr && sfrAddr == 8'hf9 && ctrlReg[2] && ctrlReg[7]
    |=> conv0Code == {low0Reg, 4'h0}) else $error("eight-bit code wrong");
  held_codes_a: assert property (heldWrite_s |=> $stable(conv0Code) && $stable(conv1Code))
    else $error("held write moved a code");
  sync_load_a: assert property (syncRise_s |=> conv0Code == {high0Reg[3:0], low0Reg})
    else $error("sync rise did not load code");
  power_off_a: assert property (!ctrlReg[0] |=> conv0OutState == ddc_pkg::DDC_OUT_HIZ)
    else $error("unpowered output not high impedance");
  clear_zero_a: assert property (ctrlReg[1] && !ctrlReg[4] |=> conv1OutState == ddc_pkg::DDC_OUT_ZERO)
    else $error("cleared output not zero");
  range_follow_a: assert property (1'b1 |=> conv1RangeSelect == $past(ctrlReg[6]))
    else $error("range select does not follow control");
  bypass_range_a: assert property (conv0BufferBypass |-> !conv0RangeSelect)
    else $error("bypass granted on supply range");
endmodule
bind ddc_control ddc_control_monitor mon_u (.clk(clk), .rst(rst), .sfrAddr(sfrAddr),
  .sfrWr(sfrWr), .sfrRd(sfrRd), .sfrWrData(sfrWrData), .sfrRdHit(sfrRdHit),
  .conv0Code(conv0Code), .conv1Code(conv1Code), .conv0OutState(conv0OutState),
  .conv1OutState(conv1OutState), .conv0RangeSelect(conv0RangeSelect),
  .conv1RangeSelect(conv1RangeSelect), .conv0BufferBypass(conv0BufferBypass));

// ### verif/ddc_conv_model.sv
// Behavioural model of one converter output stage.
module ddc_conv_model (
  // Controls from the block.
  input  wire ddc_pkg::ddc_code_t code,
  input  wire ddc_pkg::ddc_out_t  outState,
  input  wire logic               rangeSupply,
  input  wire logic               bypass,
  // Modelled output level and whether it is driven.
  output ddc_pkg::ddc_code_t      level,
  output logic                    driven
);
  timeunit 1ns;
  timeprecision 1ps;
  ddc_pkg::ddc_code_t lastLevel = 12'h000;
  // A released output shows the inverse of its last level, so stale values never pass.
  // The reference range is taken as valid, since software keeps the sampling converter on.
  always @* begin
    driven = (outState != ddc_pkg::DDC_OUT_HIZ) && !(bypass && rangeSupply);
    if (!driven) level = ~lastLevel;
    else if (outState == ddc_pkg::DDC_OUT_ZERO) level = 12'h000;
    else level = code;
    if (driven) lastLevel = level;
  end
endmodule

// ### verif/tb_top.sv
// Self-checking testbench for the dual converter control block.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic [7:0]         sfrAddr = 8'h00;
  logic               sfrWr = 1'b0;
  logic               sfrRd = 1'b0;
  ddc_pkg::ddc_byte_t sfrWrData = 8'h00;
  logic               bypassIn = 1'b0;
  ddc_pkg::ddc_byte_t sfrRdData;
  logic               sfrRdHit;
  ddc_pkg::ddc_code_t code0, code1, level0;
  ddc_pkg::ddc_out_t  state0, state1;
  logic               range0, range1, byp0, byp1, driven0;
  ddc_pkg::ddc_byte_t ctl[5] = '{8'h7c, 8'h1e, 8'h0f, 8'h17, 8'h67};
  int                 err_count = 0;
  int                 cmp_count = 0;
  ddc_control dut_u (.clk(clk), .rst(rst), .sfrAddr(sfrAddr), .sfrWr(sfrWr), .sfrRd(sfrRd),
    .sfrWrData(sfrWrData), .sfrRdData(sfrRdData), .sfrRdHit(sfrRdHit),
    .outputBufferBypass(bypassIn), .conv0Code(code0), .conv0OutState(state0),
    .conv0RangeSelect(range0), .conv0BufferBypass(byp0), .conv1Code(code1),
    .conv1OutState(state1), .conv1RangeSelect(range1), .conv1BufferBypass(byp1));
  ddc_conv_model model_u (.code(code0), .outState(state0), .rangeSupply(range0),
    .bypass(byp0), .level(level0), .driven(driven0));
  // Clock of 8 ns.
  initial forever #4 clk = ~clk;
  // Bus tasks hold the strobe for exactly the one edge that takes it.
  task automatic wr(input logic [7:0] a, input ddc_pkg::ddc_byte_t d);
    @(posedge clk);
    sfrAddr <= a;
    sfrWrData <= d;
    sfrWr <= 1'b1;
    @(posedge clk);
    sfrWr <= 1'b0;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkState(input ddc_pkg::ddc_out_t got, input ddc_pkg::ddc_out_t exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input ddc_pkg::ddc_byte_t exp, input logic hit);
    @(posedge clk);
    sfrAddr <= a;
    sfrRd <= 1'b1;
    @(posedge clk);
    sfrRd <= 1'b0;
    @(negedge clk);
    chk(12'(sfrRdData), 12'(exp));
    chk(12'(sfrRdHit), 12'(hit));
  endtask
  // Output states settle one edge after the control register.
  task automatic settle;
    repeat (2) @(negedge clk);
  endtask
  function automatic ddc_pkg::ddc_out_t expSt(input logic pwr, input logic clrN);
    return !pwr ? ddc_pkg::DDC_OUT_HIZ : (!clrN ? ddc_pkg::DDC_OUT_ZERO : ddc_pkg::DDC_OUT_CODE);
  endfunction
  task automatic endTest(input string n);
    $display("test %s done", n);
  endtask
  task automatic final_report;
    $display("compares=%0d mismatches=%0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Main sequence.
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(8'hfd, 8'h04, 1'b1);
    for (int i = 0; i < 4; i++) rd(8'hf9 + 8'(i), 8'h00, 1'b1);
    rd(8'hfe, 8'h00, 1'b0);
    chkState(state0, ddc_pkg::DDC_OUT_HIZ);
    chkState(state1, ddc_pkg::DDC_OUT_HIZ);
    chk(12'(driven0), 12'h000);
    endTest("reset");
    wr(8'hfd, 8'h1f);
    wr(8'hfa, 8'ha5);
    wr(8'hf9, 8'h3c);
    settle();
    chk(code0, 12'h53c);
    chk(level0, 12'h53c);
    chk(code1, 12'h000);
    chkState(state0, ddc_pkg::DDC_OUT_CODE);
    chk(12'(driven0), 12'h001);
    rd(8'hfa, 8'ha5, 1'b1);
    endTest("immediate");
    wr(8'hfd, 8'h1b);
    wr(8'hfc, 8'hfc);
    wr(8'hfb, 8'h12);
    wr(8'hfa, 8'h01);
    wr(8'hf9, 8'h02);
    settle();
    chk(code0, 12'h53c);
    chk(code1, 12'h000);
    wr(8'hfd, 8'h1f);
    settle();
    chk(code0, 12'h102);
    chk(code1, 12'hc12);
    endTest("sync");
    foreach (ctl[i]) begin
      wr(8'hfd, ctl[i]);
      settle();
      chkState(state0, expSt(ctl[i][0], ctl[i][3]));
      chkState(state1, expSt(ctl[i][1], ctl[i][4]));
      chk(12'(range0), 12'(ctl[i][5]));
      chk(12'(range1), 12'(ctl[i][6]));
      chk(12'(driven0), 12'(ctl[i][0]));
    end
    endTest("controls");
    wr(8'hfd, 8'h9f);
    wr(8'hf9, 8'h7e);
    settle();
    chk(code0, 12'h7e0);
    wr(8'hfd, 8'h9b);
    wr(8'hf9, 8'h44);
    settle();
    chk(code0, 12'h7e0);
    wr(8'hfd, 8'h1f);
    settle();
    chk(code0, 12'h144);
    endTest("eight-bit");
    @(posedge clk);
    bypassIn <= 1'b1;
    wr(8'hfd, 8'h5f);
    settle();
    chk(12'(byp0), 12'h001);
    chk(12'(byp1), 12'h000);
    chk(12'(driven0), 12'h001);
    wr(8'hfe, 8'hff);
    rd(8'hfd, 8'h5f, 1'b1);
    endTest("bypass");
    // A second reset in mid-run must bring back the power-on state.
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(8'hfd, 8'h04, 1'b1);
    rd(8'hf9, 8'h00, 1'b1);
    chk(code0, 12'h000);
    chk(code1, 12'h000);
    chkState(state0, ddc_pkg::DDC_OUT_HIZ);
    endTest("rerun reset");
    final_report();
  end
  // Watchdog against a hang.
  initial begin
    repeat (3000) @(posedge clk);
    err_count++;
    final_report();
  end
endmodule
